//--- core/pid_loop_output_control.v
// Furnace PID loop with output modes, limits, stop conditions and accumulators.
`timescale 1ns/1ps
`include "pid_loop_defs.vh"

module pid_loop_output_control #(
	// Sample period in clock cycles; a bench may shorten it to reach ticks quickly.
	parameter [31:0] TICK_CYCLES = `SAMPLE_CYCLES
) (
	// Clock and reset
	input wire CLK,
	input wire RST,
	// Process inputs
	input wire signed [15:0] PROCESS_VALUE,
	input wire signed [15:0] TARGET_VALUE,
	input wire [2:0] INPUT_HIGH_LIMIT,
	// Gain sets 1..3: band in tenths, reset and rate in hundredths
	input wire [15:0] BAND_ONE,
	input wire [15:0] RESET_ONE,
	input wire [15:0] RATE_ONE,
	input wire [15:0] BAND_TWO,
	input wire [15:0] RESET_TWO,
	input wire [15:0] RATE_TWO,
	input wire [15:0] BAND_THREE,
	input wire [15:0] RESET_THREE,
	input wire [15:0] RATE_THREE,
	input wire AUTO_SWITCH,
	input wire signed [15:0] SWITCH_ONE_TWO,
	input wire signed [15:0] SWITCH_TWO_THREE,
	// Loop configuration
	input wire [1:0] LOOP_MODE,
	input wire signed [15:0] INTEGRAL_PRESET,
	input wire [15:0] CYCLE_TIME,
	input wire [2:0] CHANGE_LIMIT_SEL,
	input wire signed [15:0] OUT_LOW_LIMIT,
	input wire signed [15:0] OUT_HIGH_LIMIT,
	input wire signed [15:0] SP_LOW_LIMIT,
	input wire signed [15:0] SP_HIGH_LIMIT,
	input wire ZERO_SP_STOP,
	input wire input_one_limit_stop,
	input wire input_two_limit_stop,
	input wire input_three_limit_stop,
	input wire OVERSHOOT_ENABLE,
	// Accumulator reset commands
	input wire CLEAR_POS_ACC,
	input wire CLEAR_NEG_ACC,
	// Outputs
	output reg signed [15:0] LOOP_OUTPUT,
	output reg signed [15:0] HEAT_OUTPUT,
	output reg signed [15:0] COOL_OUTPUT,
	output reg HEAT_RELAY,
	output reg COOL_RELAY,
	output reg signed [15:0] WORKING_SETPOINT,
	output reg [1:0] ACTIVE_SET,
	output reg [15:0] CYCLE_TIME_ACTIVE,
	output reg LOOP_STOPPED,
	output reg [31:0] POS_ACC,
	output reg [31:0] NEG_ACC,
	output reg SAMPLE_TICK
);

	reg [2:0] lim_meta;
	reg [2:0] lim_sync;
	reg [25:0] tick_count;
	reg signed [31:0] integ;
	reg signed [15:0] prev_pv;
	reg limiting;
	reg signed [15:0] last_target;
	reg ovs_hold;
	reg [15:0] cycle_count;
	reg [15:0] band;
	reg [15:0] reset_gain;
	reg [15:0] rate_gain;
	reg signed [15:0] target;
	reg signed [16:0] err;
	reg signed [31:0] p_term;
	reg signed [47:0] i_step;
	reg signed [31:0] d_term;
	reg signed [31:0] next_integ;
	reg signed [31:0] raw;
	reg signed [15:0] next_out;
	reg signed [15:0] limit_pct;
	reg stop;
	reg signed [16:0] sp_step;
	reg signed [16:0] sp_diff;

	// Limits arrive in whole percent and are scaled to tenths once here.
	reg signed [31:0] high_scaled;
	reg signed [31:0] low_scaled;
	reg signed [31:0] preset_scaled;

	// Relay on-time comparison terms and accumulator increments.
	reg [31:0] cycle_pos;
	reg [31:0] heat_share;
	reg [31:0] cool_share;
	reg [31:0] pos_add;
	reg [31:0] neg_add;

	// Terminal count of the sample divider.
	localparam [31:0] TICK_LAST = TICK_CYCLES - 32'h0000_0001;

	// Two-flop synchroniser for the input high-limit pins.
	always @(posedge CLK or posedge RST) begin
		if (RST) begin
			lim_meta <= 3'h0;
			lim_sync <= 3'h0;
		end else begin
			lim_meta <= INPUT_HIGH_LIMIT;
			lim_sync <= lim_meta;
		end
	end

	// Gain set selection by measured process value only.
	always @* begin
		ACTIVE_SET = 2'h1;
		if (AUTO_SWITCH) begin
			if (PROCESS_VALUE > SWITCH_TWO_THREE)
				ACTIVE_SET = 2'h3;
			else if (PROCESS_VALUE > SWITCH_ONE_TWO)
				ACTIVE_SET = 2'h2;
		end
		case (ACTIVE_SET)
			2'h2: begin
				band = BAND_TWO;
				reset_gain = RESET_TWO;
				rate_gain = RATE_TWO;
			end
			2'h3: begin
				band = BAND_THREE;
				reset_gain = RESET_THREE;
				rate_gain = RATE_THREE;
			end
			default: begin
				band = BAND_ONE;
				reset_gain = RESET_ONE;
				rate_gain = RATE_ONE;
			end
		endcase
		if (band > `PB_MAX)
			band = `PB_MAX;
		if (reset_gain > `GAIN_MAX)
			reset_gain = `GAIN_MAX;
		if (rate_gain > `GAIN_MAX)
			rate_gain = `GAIN_MAX;
	end

	// Target clamp and control-term arithmetic in tenths of a percent.
	always @* begin
		target = TARGET_VALUE;
		if (target < SP_LOW_LIMIT)
			target = SP_LOW_LIMIT;
		if (target > SP_HIGH_LIMIT)
			target = SP_HIGH_LIMIT;
		if (target < `SP_MIN)
			target = `SP_MIN;
		if (target > `SP_MAX)
			target = `SP_MAX;
		// Reverse action wants output up when process is below setpoint.
		if (LOOP_MODE[1])
			err = {PROCESS_VALUE[15], PROCESS_VALUE} - {WORKING_SETPOINT[15], WORKING_SETPOINT};
		else
			err = {WORKING_SETPOINT[15], WORKING_SETPOINT} - {PROCESS_VALUE[15], PROCESS_VALUE};
		// Band is percent of range for full output; range assumed 10 counts.
		if (band == 16'h0000)
			p_term = 32'sh0000_0000;
		else
			p_term = ($signed({{15{err[16]}}, err}) * 32'sd100000)
				/ $signed({16'h0000, band});
		i_step = ($signed({{31{err[16]}}, err}) * $signed({32'h0000_0000, reset_gain}))
			/ 48'sd6000;
		next_integ = limiting ? integ : integ + i_step[31:0];
		if (next_integ > `INTEG_LIMIT)
			next_integ = `INTEG_LIMIT;
		if (next_integ < -`INTEG_LIMIT)
			next_integ = -`INTEG_LIMIT;
		d_term = ($signed({{16{PROCESS_VALUE[15]}}, PROCESS_VALUE})
			- $signed({{16{prev_pv[15]}}, prev_pv})) * $signed({16'h0000, rate_gain}) * 32'sd10;
		if (!LOOP_MODE[1])
			d_term = -d_term;
		preset_scaled = $signed({{16{INTEGRAL_PRESET[15]}}, INTEGRAL_PRESET}) * 32'sd10;
		high_scaled = $signed({{16{OUT_HIGH_LIMIT[15]}}, OUT_HIGH_LIMIT}) * 32'sd10;
		low_scaled = $signed({{16{OUT_LOW_LIMIT[15]}}, OUT_LOW_LIMIT}) * 32'sd10;
		raw = preset_scaled + p_term + next_integ - d_term;
		if (band == 16'h0000)
			raw = (err > 17'sd0) ? 32'sd1000 : ((err < 17'sd0 && !LOOP_MODE[0]) ? -32'sd1000 : 32'sd0);
		// Clamp to the user limits first, then to full scale.
		if (raw > high_scaled)
			raw = high_scaled;
		if (raw < low_scaled)
			raw = low_scaled;
		if (raw > 32'sd1000)
			raw = 32'sd1000;
		if (raw < -32'sd1000)
			raw = -32'sd1000;
		if (LOOP_MODE[0] && raw < 32'sd0)
			raw = 32'sd0;
		stop = (ZERO_SP_STOP && TARGET_VALUE == 16'sh0000)
			|| (input_one_limit_stop && lim_sync[0])
			|| (input_two_limit_stop && lim_sync[1])
			|| (input_three_limit_stop && lim_sync[2]);
		next_out = stop ? 16'sh0000 : raw[15:0];
		case (CHANGE_LIMIT_SEL)
			3'h1: limit_pct = 16'sd800;
			3'h2: limit_pct = 16'sd700;
			3'h3: limit_pct = 16'sd600;
			3'h4: limit_pct = 16'sd500;
			3'h5: limit_pct = 16'sd400;
			3'h6: limit_pct = 16'sd300;
			3'h7: limit_pct = 16'sd200;
			default: limit_pct = 16'sd0;
		endcase
		// The difference is signed so the shift keeps the sign on a downward step.
		sp_diff = {target[15], target} - {WORKING_SETPOINT[15], WORKING_SETPOINT};
		sp_step = sp_diff >>> `OVS_SHIFT;
		// Only one of these is used on any sample, chosen by the sign of the output.
		pos_add = {16'h0000, next_out};
		neg_add = {16'h0000, -next_out};
		cycle_pos = {16'h0000, cycle_count} * 32'd1000;
		heat_share = {16'h0000, HEAT_OUTPUT} * {16'h0000, CYCLE_TIME_ACTIVE};
		cool_share = {16'h0000, COOL_OUTPUT} * {16'h0000, CYCLE_TIME_ACTIVE};
	end

	// One-second sample tick derived from the system clock.
	always @(posedge CLK or posedge RST) begin
		if (RST) begin
			tick_count <= 26'h000_0000;
			SAMPLE_TICK <= 1'b0;
		end else if (tick_count == TICK_LAST[25:0]) begin
			// The count restarts on the edge that raises the tick, so the period is exact.
			tick_count <= 26'h000_0000;
			SAMPLE_TICK <= 1'b1;
		end else begin
			tick_count <= tick_count + 26'h000_0001;
			SAMPLE_TICK <= 1'b0;
		end
	end

	// Loop update, working setpoint and accumulators on each sample.
	always @(posedge CLK or posedge RST) begin
		if (RST) begin
			integ <= 32'sh0000_0000;
			prev_pv <= 16'sh0000;
			limiting <= 1'b0;
			last_target <= 16'sh0000;
			ovs_hold <= 1'b0;
			WORKING_SETPOINT <= 16'sh0000;
			LOOP_OUTPUT <= 16'sh0000;
			HEAT_OUTPUT <= 16'sh0000;
			COOL_OUTPUT <= 16'sh0000;
			LOOP_STOPPED <= 1'b0;
			POS_ACC <= 32'h0000_0000;
			NEG_ACC <= 32'h0000_0000;
			CYCLE_TIME_ACTIVE <= 16'h0000;
		end else begin
			CYCLE_TIME_ACTIVE <= (CYCLE_TIME > `CYCLE_MAX) ? `CYCLE_MAX : CYCLE_TIME;
			if (SAMPLE_TICK) begin
				prev_pv <= PROCESS_VALUE;
				integ <= stop ? 32'sh0000_0000 : next_integ;
				LOOP_OUTPUT <= next_out;
				LOOP_STOPPED <= stop;
				// Dual modes split the signed output over two actuators.
				HEAT_OUTPUT <= (next_out > 16'sh0000) ? next_out : 16'sh0000;
				COOL_OUTPUT <= (next_out < 16'sh0000 && !LOOP_MODE[0]) ? -next_out : 16'sh0000;
				last_target <= target;
				// Integral is held after a setpoint step until output falls below the limit.
				if (target != last_target && CHANGE_LIMIT_SEL != 3'h0)
					limiting <= 1'b1;
				else if (next_out < limit_pct || CHANGE_LIMIT_SEL == 3'h0)
					limiting <= 1'b0;
				if (OVERSHOOT_ENABLE && target != last_target
					&& (target - WORKING_SETPOINT > `OVS_TRIGGER
					|| WORKING_SETPOINT - target > `OVS_TRIGGER)) begin
					ovs_hold <= 1'b1;
					WORKING_SETPOINT <= (target > WORKING_SETPOINT) ? target - `OVS_BAND
						: target + `OVS_BAND;
				end else if (ovs_hold) begin
					if ((last_target > WORKING_SETPOINT && PROCESS_VALUE >= WORKING_SETPOINT)
						|| (last_target < WORKING_SETPOINT && PROCESS_VALUE <= WORKING_SETPOINT))
						ovs_hold <= 1'b0;
				end else if (OVERSHOOT_ENABLE && WORKING_SETPOINT != target) begin
					// A step of zero would stall short of the target, so finish it directly.
					if (sp_step == 17'sd0)
						WORKING_SETPOINT <= target;
					else
						WORKING_SETPOINT <= WORKING_SETPOINT + sp_step[15:0];
				end else begin
					WORKING_SETPOINT <= target;
				end
			end
			// A clear in the same cycle as a sample wins; accumulation resumes next sample.
			if (CLEAR_POS_ACC)
				POS_ACC <= 32'h0000_0000;
			else if (SAMPLE_TICK && next_out > 16'sh0000)
				POS_ACC <= (POS_ACC > `ACC_MAX - pos_add) ? `ACC_MAX
					: POS_ACC + pos_add;
			if (CLEAR_NEG_ACC)
				NEG_ACC <= 32'h0000_0000;
			else if (SAMPLE_TICK && next_out < 16'sh0000)
				NEG_ACC <= (NEG_ACC > `ACC_MAX - neg_add) ? `ACC_MAX
					: NEG_ACC + neg_add;
		end
	end

	// Relays are time-proportioned over the cycle time in seconds.
	always @(posedge CLK or posedge RST) begin
		if (RST) begin
			cycle_count <= 16'h0000;
			HEAT_RELAY <= 1'b0;
			COOL_RELAY <= 1'b0;
		end else if (SAMPLE_TICK) begin
			cycle_count <= (cycle_count + 16'h0001 >= CYCLE_TIME_ACTIVE) ? 16'h0000
				: cycle_count + 16'h0001;
			HEAT_RELAY <= (cycle_pos < heat_share)
				|| (CYCLE_TIME_ACTIVE == 16'h0000 && HEAT_OUTPUT > 16'sh0000);
			COOL_RELAY <= (cycle_pos < cool_share)
				|| (CYCLE_TIME_ACTIVE == 16'h0000 && COOL_OUTPUT > 16'sh0000);
		end
	end

endmodule // pid_loop_output_control

//--- include/pid_loop_defs.vh
// Constants for the furnace loop output controller.
`ifndef PID_LOOP_DEFS_VH
`define PID_LOOP_DEFS_VH
`define CLK_HZ 40000000
`define SAMPLE_PERIOD_S 1
`define SAMPLE_CYCLES (`CLK_HZ * `SAMPLE_PERIOD_S)
`define OUT_FULL 16'sh03E8
`define OUT_NEG_FULL -16'sh03E8
`define GAIN_MAX 16'h7FFF
`define PB_MAX 16'h7FF8
`define CYCLE_MAX 16'h01F4
`define SP_MIN -16'sh012C
`define SP_MAX 16'sh270F
`define SWITCH_MAX 16'sh0FA0
`define ACC_MAX 32'hFFFF_FFFF
`define MODE_DUAL_REVERSE 2'h0
`define MODE_SINGLE_REVERSE 2'h1
`define MODE_DUAL_DIRECT 2'h2
`define MODE_SINGLE_DIRECT 2'h3
`define INTEG_LIMIT 32'sh000F_4240
`define OVS_BAND 16'sh0032
`define OVS_TRIGGER 16'sh00C8
`define OVS_SHIFT 3
`endif

//--- test/furnace_model.sv
// Furnace sensor model that supplies the process value and input high limit pins.
`timescale 1ns/1ps
module furnace_model (
	// Clock and reset
	input wire clk,
	input wire rst,
	// Demand from the bench
	input wire signed [15:0] pv_demand,
	input wire signed [15:0] high_point,
	// Sensor side
	output reg signed [15:0] process_value,
	output reg [2:0] high_limit
);
	// The transmitter lags one cycle, so the bench never sees its own demand at once.
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			process_value <= 16'sh0000;
			high_limit <= 3'h0;
		end else begin
			process_value <= pv_demand;
			high_limit <= {3{pv_demand >= high_point}};
		end
	end
endmodule // furnace_model

//--- test/pid_checks_props.sv
// Concurrent checks on the loop controller's ports.
`timescale 1ns/1ps
`include "pid_loop_defs.vh"
module pid_checks (
	// Clock and reset
	input wire CLK,
	input wire RST,
	// Watched ports
	input wire signed [15:0] PROCESS_VALUE,
	input wire AUTO_SWITCH,
	input wire signed [15:0] SWITCH_ONE_TWO,
	input wire signed [15:0] SWITCH_TWO_THREE,
	input wire CLEAR_POS_ACC,
	input wire CLEAR_NEG_ACC,
	input wire signed [15:0] LOOP_OUTPUT,
	input wire signed [15:0] HEAT_OUTPUT,
	input wire signed [15:0] COOL_OUTPUT,
	input wire [1:0] ACTIVE_SET,
	input wire [15:0] CYCLE_TIME_ACTIVE,
	input wire LOOP_STOPPED,
	input wire [31:0] POS_ACC,
	input wire [31:0] NEG_ACC,
	input wire SAMPLE_TICK
);
	default clocking @(posedge CLK); endclocking
	default disable iff (RST);
	sequence held_stop;
		LOOP_STOPPED [*2];
	endsequence
	tick_pulse_a: assert property (SAMPLE_TICK |=> !SAMPLE_TICK)
		else $error("sample tick wider than one cycle");
	output_hold_a: assert property (!$past(SAMPLE_TICK) |-> $stable(LOOP_OUTPUT))
		else $error("loop output moved without a sample");
	output_range_a: assert property (LOOP_OUTPUT >= `OUT_NEG_FULL && LOOP_OUTPUT <= `OUT_FULL)
		else $error("loop output beyond full scale");
	pos_grow_a: assert property (!$past(CLEAR_POS_ACC) |-> POS_ACC >= $past(POS_ACC))
		else $error("positive total fell or wrapped");
	neg_grow_a: assert property (!$past(CLEAR_NEG_ACC) |-> NEG_ACC >= $past(NEG_ACC))
		else $error("negative total fell or wrapped");
	pos_clear_a: assert property (CLEAR_POS_ACC |=> POS_ACC == 32'h0000_0000)
		else $error("positive total not cleared");
	neg_clear_a: assert property (CLEAR_NEG_ACC |=> NEG_ACC == 32'h0000_0000)
		else $error("negative total not cleared");
	set_select_a: assert property (AUTO_SWITCH && SWITCH_ONE_TWO <= SWITCH_TWO_THREE |->
		ACTIVE_SET == (PROCESS_VALUE > SWITCH_TWO_THREE ? 2'h3 :
		PROCESS_VALUE > SWITCH_ONE_TWO ? 2'h2 : 2'h1))
		else $error("wrong gain set for process value");
	stop_outputs_a: assert property (held_stop |-> LOOP_OUTPUT == 0 && HEAT_OUTPUT == 0 &&
		COOL_OUTPUT == 0)
		else $error("outputs live while stopped");
	cycle_clamp_a: assert property (CYCLE_TIME_ACTIVE <= `CYCLE_MAX)
		else $error("cycle time above its ceiling");
endmodule // pid_checks
bind pid_loop_output_control pid_checks pid_checks_inst (.*);

//--- test/tb_top.sv
// Self-checking bench for the furnace loop output controller.
`timescale 1ns/1ps
`define CHECK(got, exp) begin samples_checked++; if ((got) !== (exp)) begin miscompares++; \
	$display("wrong value at %0t: got %h expected %h", $time, got, exp); end end
module tb_top;
	reg CLK = 1'b0, RST = 1'b1;
	reg [15:0] BAND_ONE = 16'h03E8, RESET_ONE = 16'h0000, RATE_ONE = 16'h0000;
	reg [15:0] BAND_TWO = 16'h000D, RESET_TWO = 16'h00E6, RATE_TWO = 16'h014A;
	reg [15:0] BAND_THREE = 16'h0010, RESET_THREE = 16'h0104, RATE_THREE = 16'h0168;
	reg [15:0] CYCLE_TIME = 16'h0064;
	reg signed [15:0] TARGET_VALUE = 16'sh01F4, SWITCH_ONE_TWO = 16'sh0320;
	reg signed [15:0] SWITCH_TWO_THREE = 16'sh05DC, INTEGRAL_PRESET = 16'sh0000;
	reg signed [15:0] OUT_LOW_LIMIT = -16'sh0064, OUT_HIGH_LIMIT = 16'sh0064;
	reg signed [15:0] SP_LOW_LIMIT = -16'sh012C, SP_HIGH_LIMIT = 16'sh270F;
	reg signed [15:0] pv_demand = 16'sh0000, high_point = 16'sh0FA0;
	reg AUTO_SWITCH = 1'b0, ZERO_SP_STOP = 1'b0, OVERSHOOT_ENABLE = 1'b0;
	reg input_one_limit_stop = 1'b0, input_two_limit_stop = 1'b0, input_three_limit_stop = 1'b0;
	reg CLEAR_POS_ACC = 1'b0, CLEAR_NEG_ACC = 1'b0;
	reg [1:0] LOOP_MODE = 2'h1;
	reg [2:0] CHANGE_LIMIT_SEL = 3'h0;
	wire signed [15:0] PROCESS_VALUE, LOOP_OUTPUT, HEAT_OUTPUT, COOL_OUTPUT, WORKING_SETPOINT;
	wire [2:0] INPUT_HIGH_LIMIT;
	wire HEAT_RELAY, COOL_RELAY, LOOP_STOPPED, SAMPLE_TICK;
	wire [1:0] ACTIVE_SET;
	wire [15:0] CYCLE_TIME_ACTIVE;
	wire [31:0] POS_ACC, NEG_ACC;
	int miscompares = 0, samples_checked = 0, cycles = 0;
	pid_loop_output_control #(.TICK_CYCLES(32'h0000_0064)) pid_loop_output_control_inst (.*);
	furnace_model furnace_model_inst (.clk(CLK), .rst(RST), .pv_demand(pv_demand),
		.high_point(high_point), .process_value(PROCESS_VALUE), .high_limit(INPUT_HIGH_LIMIT));
	always #12.5 CLK = ~CLK;
	task complete_run;
		if (miscompares == 0 && samples_checked > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	always @(posedge CLK) begin
		cycles++;
		if (cycles == 3000) begin
			miscompares++;
			complete_run;
		end
	end
	task automatic probe(input [15:0] pv, input [1:0] want);
		@(posedge CLK);
		pv_demand <= pv;
		repeat (2) @(posedge CLK);
		@(negedge CLK);
		`CHECK(ACTIVE_SET, want)
	endtask
	// Waits for the edge that takes a sample, then looks while the new outputs stand.
	task wait_tick;
		@(posedge CLK iff SAMPLE_TICK);
		@(negedge CLK);
	endtask
	// The sample period is shortened to 100 cycles; band 100.0 % gives 10.0 % per count.
	initial begin
		repeat (4) @(posedge CLK);
		RST <= 1'b0;
		@(negedge CLK);
		`CHECK(LOOP_OUTPUT, 16'sh0000)
		`CHECK(POS_ACC, 32'h0000_0000)
		`CHECK(NEG_ACC, 32'h0000_0000)
		`CHECK(WORKING_SETPOINT, 16'sh0000)
		@(posedge CLK);
		pv_demand <= 16'sh01EF;
		wait_tick;
		`CHECK(LOOP_OUTPUT, 16'sh0000)
		wait_tick;
		`CHECK(LOOP_OUTPUT, 16'sh01F4)
		`CHECK(HEAT_OUTPUT, 16'sh01F4)
		`CHECK(WORKING_SETPOINT, 16'sh01F4)
		`CHECK(SAMPLE_TICK, 1'b0)
		@(posedge CLK);
		OUT_HIGH_LIMIT <= 16'sh001E;
		wait_tick;
		`CHECK(LOOP_OUTPUT, 16'sh012C)
		@(posedge CLK);
		OUT_HIGH_LIMIT <= 16'sh0064;
		INTEGRAL_PRESET <= 16'sh000A;
		wait_tick;
		`CHECK(LOOP_OUTPUT, 16'sh0258)
		`CHECK(POS_ACC, 32'h0000_0578)
		@(posedge CLK);
		LOOP_MODE <= 2'h0;
		pv_demand <= 16'sh01F9;
		wait_tick;
		`CHECK(LOOP_OUTPUT, -16'sh0190)
		`CHECK(COOL_OUTPUT, 16'sh0190)
		`CHECK(NEG_ACC, 32'h0000_0190)
		@(posedge CLK);
		LOOP_MODE <= 2'h2;
		wait_tick;
		`CHECK(LOOP_OUTPUT, 16'sh0258)
		@(posedge CLK);
		pv_demand <= 16'sh01FA;
		RATE_ONE <= 16'h0001;
		wait_tick;
		`CHECK(LOOP_OUTPUT, 16'sh02B2)
		@(posedge CLK);
		BAND_ONE <= 16'h0000;
		wait_tick;
		`CHECK(LOOP_OUTPUT, 16'sh03E8)
		`CHECK(POS_ACC, 32'h0000_0E6A)
		@(posedge CLK);
		ZERO_SP_STOP <= 1'b1;
		TARGET_VALUE <= 16'sh0000;
		wait_tick;
		`CHECK(LOOP_STOPPED, 1'b1)
		`CHECK(HEAT_OUTPUT, 16'sh0000)
		@(posedge CLK);
		ZERO_SP_STOP <= 1'b0;
		TARGET_VALUE <= 16'sh01F4;
		input_one_limit_stop <= 1'b1;
		high_point <= 16'sh0000;
		wait_tick;
		`CHECK(LOOP_STOPPED, 1'b1)
		@(posedge CLK);
		input_one_limit_stop <= 1'b0;
		wait_tick;
		`CHECK(LOOP_STOPPED, 1'b0)
		`CHECK(LOOP_OUTPUT, 16'sh03E8)
		@(posedge CLK);
		high_point <= 16'sh0FA0;
		AUTO_SWITCH <= 1'b1;
		probe(16'h0000, 2'h1);
		probe(16'h0320, 2'h1);
		probe(16'h0321, 2'h2);
		probe(16'h05DC, 2'h2);
		probe(16'h05DD, 2'h3);
		@(posedge CLK);
		TARGET_VALUE <= 16'sh270F;
		probe(16'h0000, 2'h1);
		@(posedge CLK);
		SWITCH_TWO_THREE <= 16'sh0FA0;
		CLEAR_POS_ACC <= 1'b1;
		CLEAR_NEG_ACC <= 1'b1;
		@(posedge CLK);
		CLEAR_POS_ACC <= 1'b0;
		CLEAR_NEG_ACC <= 1'b0;
		@(negedge CLK);
		`CHECK(POS_ACC, 32'h0000_0000)
		`CHECK(NEG_ACC, 32'h0000_0000)
		probe(16'h0FA0, 2'h2);
		@(posedge CLK);
		TARGET_VALUE <= 16'sh0000;
		ZERO_SP_STOP <= 1'b1;
		input_one_limit_stop <= 1'b1;
		input_two_limit_stop <= 1'b1;
		input_three_limit_stop <= 1'b1;
		LOOP_MODE <= 2'h3;
		CHANGE_LIMIT_SEL <= 3'h7;
		OVERSHOOT_ENABLE <= 1'b1;
		CYCLE_TIME <= 16'h01F4;
		wait_tick;
		`CHECK(LOOP_STOPPED, 1'b1)
		`CHECK(SAMPLE_TICK, 1'b0)
		`CHECK(LOOP_OUTPUT, 16'sh0000)
		complete_run;
	end
endmodule // tb_top
